//--- src/alc_limit_check.sv
// The implementer's own choice: the address-and-strobe port.
module alc_limit_check #(
    parameter int ADDR_W = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  alc_pkg::alc_conv_t     conv_in,
    output alc_pkg::alc_res_t      res_out,
    output logic                   irq_first,
    output logic                   irq_second
);

    logic [14:0] gain_q;
    logic [15:0] low_thr_q;
    logic [15:0] low_hys_q;
    logic [15:0] high_thr_q;
    logic [15:0] high_hys_q;
    logic [15:0] step_lim_q;
    logic [2:0]  flags1_q;
    logic [2:0]  flags2_q;
    logic [2:0]  mask1_q;
    logic [2:0]  mask2_q;
    logic        low_state_q;
    logic        high_state_q;
    logic        have_prev_q;
    logic [15:0] prev_q;
    logic [31:0] rdata_q;
    alc_pkg::alc_res_t res_q;

    logic [15:0] corr;
    logic [16:0] low_release;
    logic [16:0] high_release;
    logic        below_low;
    logic        above_low_rel;
    logic        above_high;
    logic        below_high_rel;
    logic        step_err;
    logic        conv_take;
    logic [2:0]  ev_set;
    logic [2:0]  clr1;
    logic [2:0]  clr2;
    logic        wr_en;
    logic        rd_en;

    // raw times q1.14 code, saturated to 16 bits
    function automatic logic [15:0] apply_gain(
        input logic [15:0] raw,
        input logic [14:0] g
    );
        logic [30:0] prod;
        prod = 31'(raw) * 31'(g);
        if (prod[30]) begin
            apply_gain = 16'hffff;
        end else begin
            apply_gain = prod[29:14];
        end
    endfunction : apply_gain

    // unsigned distance between two results
    function automatic logic [15:0] abs_diff(
        input logic [15:0] a,
        input logic [15:0] b
    );
        if (a >= b) begin
            abs_diff = a - b;
        end else begin
            abs_diff = b - a;
        end
    endfunction : abs_diff

    // bus strobes qualified by the clock enable
    assign wr_en     = clk_en && reg_wr;
    assign rd_en     = clk_en && reg_rd;
    assign conv_take = clk_en && conv_in.valid;

    // gain only on the temperature channel; code zero gives zero naturally
    always_comb begin
        if (conv_in.temp_chan) begin
            corr = apply_gain(conv_in.data, gain_q);
        end else begin
            corr = conv_in.data;
        end
    end

    // unsigned compares; 17 bits so the margins cannot wrap
    assign low_release  = {1'b0, low_thr_q} + {1'b0, low_hys_q};
    assign high_release = {1'b0, high_thr_q} - {1'b0, high_hys_q};
    assign below_low      = corr < low_thr_q;
    assign above_low_rel  = {1'b0, corr} > low_release;
    assign above_high     = corr > high_thr_q;
    // release below a negative margin can never happen
    assign below_high_rel = !high_release[16]
                            && ({1'b0, corr} < high_release);
    assign step_err = have_prev_q
                      && (abs_diff(corr, prev_q) > step_lim_q);

    // one event vector feeds both flag registers
    always_comb begin
        ev_set = alc_pkg::EV_RST;
        if (conv_take) begin
            ev_set[alc_pkg::EV_LOW]  = below_low
                                       || (low_state_q && !above_low_rel);
            ev_set[alc_pkg::EV_HIGH] = above_high
                                       || (high_state_q && !below_high_rel);
            ev_set[alc_pkg::EV_STEP] = step_err;
        end
    end

    // write-one-to-clear requests
    always_comb begin
        clr1 = alc_pkg::EV_RST;
        clr2 = alc_pkg::EV_RST;
        if (wr_en && reg_addr == alc_pkg::OFS_FLAGS_1) begin
            clr1 = reg_wdata[alc_pkg::EV_W-1:0];
        end
        if (wr_en && reg_addr == alc_pkg::OFS_FLAGS_2) begin
            clr2 = reg_wdata[alc_pkg::EV_W-1:0];
        end
    end

    // limit and gain registers; only the low field is kept
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gain_q     <= alc_pkg::GAIN_RST;
            low_thr_q  <= alc_pkg::LIMIT_RST;
            low_hys_q  <= alc_pkg::LIMIT_RST;
            high_thr_q <= alc_pkg::LIMIT_RST;
            high_hys_q <= alc_pkg::LIMIT_RST;
            step_lim_q <= alc_pkg::LIMIT_RST;
        end else if (wr_en) begin
            unique case (reg_addr)
                alc_pkg::OFS_GAIN_TRIM: gain_q <= reg_wdata[14:0];
                alc_pkg::OFS_LOW_THR:   low_thr_q  <= reg_wdata[15:0];
                alc_pkg::OFS_LOW_HYS:   low_hys_q  <= reg_wdata[15:0];
                alc_pkg::OFS_HIGH_THR:  high_thr_q <= reg_wdata[15:0];
                alc_pkg::OFS_HIGH_HYS:  high_hys_q <= reg_wdata[15:0];
                alc_pkg::OFS_STEP_LIM:  step_lim_q <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // interrupt masks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask1_q <= alc_pkg::EV_RST;
            mask2_q <= alc_pkg::EV_RST;
        end else if (wr_en) begin
            if (reg_addr == alc_pkg::OFS_MASK_1) begin
                mask1_q <= reg_wdata[alc_pkg::EV_W-1:0];
            end
            if (reg_addr == alc_pkg::OFS_MASK_2) begin
                mask2_q <= reg_wdata[alc_pkg::EV_W-1:0];
            end
        end
    end

    // sticky flags: a set in the clearing cycle survives
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags1_q <= alc_pkg::EV_RST;
            flags2_q <= alc_pkg::EV_RST;
        end else if (clk_en) begin
            flags1_q <= (flags1_q & ~clr1) | ev_set;
            flags2_q <= (flags2_q & ~clr2) | ev_set;
        end
    end

    // hysteresis states; a held state keeps re-setting its flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_state_q  <= 1'b0;
            high_state_q <= 1'b0;
        end else if (conv_take) begin
            if (below_low) begin
                low_state_q <= 1'b1;
            end else if (above_low_rel) begin
                low_state_q <= 1'b0;
            end
            if (above_high) begin
                high_state_q <= 1'b1;
            end else if (below_high_rel) begin
                high_state_q <= 1'b0;
            end
        end
    end

    // previous result for the step check
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            have_prev_q <= 1'b0;
            prev_q      <= 16'h0000;
        end else if (conv_take) begin
            have_prev_q <= 1'b1;
            prev_q      <= corr;
        end
    end

    // corrected result out, one cycle after the conversion
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            res_q <= '0;
        end else if (clk_en) begin
            res_q.valid <= conv_in.valid;
            if (conv_in.valid) begin
                res_q.data <= corr;
            end
        end
    end

    // read data one cycle after the strobe, zero on other enabled cycles, held while the enable is low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_q <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    alc_pkg::OFS_GAIN_TRIM:
                        rdata_q <= {17'h0, gain_q};
                    alc_pkg::OFS_LOW_THR:
                        rdata_q <= {16'h0, low_thr_q};
                    alc_pkg::OFS_LOW_HYS:   rdata_q <= {16'h0, low_hys_q};
                    alc_pkg::OFS_HIGH_THR:  rdata_q <= {16'h0, high_thr_q};
                    alc_pkg::OFS_HIGH_HYS:  rdata_q <= {16'h0, high_hys_q};
                    alc_pkg::OFS_STEP_LIM:  rdata_q <= {16'h0, step_lim_q};
                    alc_pkg::OFS_FLAGS_1:   rdata_q <= {29'h0, flags1_q};
                    alc_pkg::OFS_MASK_1:    rdata_q <= {29'h0, mask1_q};
                    alc_pkg::OFS_FLAGS_2:   rdata_q <= {29'h0, flags2_q};
                    alc_pkg::OFS_MASK_2:    rdata_q <= {29'h0, mask2_q};
                    alc_pkg::OFS_STATUS: begin
                        rdata_q[alc_pkg::ST_LOW_POS]  <= low_state_q;
                        rdata_q[alc_pkg::ST_HIGH_POS] <= high_state_q;
                        rdata_q[alc_pkg::ST_RES_POS +: alc_pkg::RES_W]
                            <= res_q.data;
                    end
                    default: ;
                endcase
            end
        end
    end

    // outputs
    assign reg_rdata  = rdata_q;
    assign res_out    = res_q;
    assign irq_first  = |(flags1_q & mask1_q);
    assign irq_second = |(flags2_q & mask2_q);

    // zero gain on the temperature channel yields zero
    property p_gain_zero;
        @(posedge sys_clk) disable iff (rst)
        conv_take && conv_in.temp_chan && gain_q == 15'h0000
        |=> res_q.data == 16'h0000;
    endproperty
    a_gain_zero: assert property (p_gain_zero)
        else $error("zero gain did not give zero");

    // half-unity code 0x2000 halves the raw value
    property p_gain_half;
        @(posedge sys_clk) disable iff (rst)
        conv_take && conv_in.temp_chan && gain_q == 15'h2000
        |=> res_q.data == ($past(conv_in.data) >> 1);
    endproperty
    a_gain_half: assert property (p_gain_half)
        else $error("half gain result wrong");

    // other channels pass untouched whatever the gain
    property p_bypass;
        @(posedge sys_clk) disable iff (rst)
        conv_take && !conv_in.temp_chan
        |=> res_q.valid && res_q.data == $past(conv_in.data);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("non-temperature result altered");

    // gain field back at unity after reset
    property p_gain_reset;
        @(posedge sys_clk)
        $past(rst) |-> gain_q == alc_pkg::GAIN_RST;
    endproperty
    a_gain_reset: assert property (p_gain_reset)
        else $error("gain not unity after reset");

    // a low breach reaches both flag registers
    property p_low_set;
        @(posedge sys_clk) disable iff (rst)
        conv_take && corr < low_thr_q
        |=> low_state_q && flags1_q[alc_pkg::EV_LOW]
            && flags2_q[alc_pkg::EV_LOW];
    endproperty
    a_low_set: assert property (p_low_set)
        else $error("low breach not flagged");

    // inside the low band the state is held
    property p_low_hold;
        @(posedge sys_clk) disable iff (rst)
        conv_take && low_state_q && {1'b0, corr} <= low_release
        |=> low_state_q;
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low state released early");

    // a high breach reaches both flag registers
    property p_high_set;
        @(posedge sys_clk) disable iff (rst)
        conv_take && corr > high_thr_q
        |=> high_state_q && flags1_q[alc_pkg::EV_HIGH]
            && flags2_q[alc_pkg::EV_HIGH];
    endproperty
    a_high_set: assert property (p_high_set)
        else $error("high breach not flagged");

    // high state released only below the margin
    property p_high_release;
        @(posedge sys_clk) disable iff (rst)
        high_state_q ##1 !high_state_q |-> $past(conv_take)
            && {1'b0, $past(corr)} < $past(high_release);
    endproperty
    a_high_release: assert property (p_high_release)
        else $error("high state released without cause");

    // step error raised on an oversize jump
    property p_step;
        @(posedge sys_clk) disable iff (rst)
        conv_take && have_prev_q && (abs_diff(corr, prev_q) > step_lim_q)
        |=> flags1_q[alc_pkg::EV_STEP] && flags2_q[alc_pkg::EV_STEP];
    endproperty
    a_step: assert property (p_step)
        else $error("step error not flagged");

    // upper bits of the high threshold register read zero
    property p_rsvd;
        @(posedge sys_clk) disable iff (rst)
        rd_en && reg_addr == alc_pkg::OFS_HIGH_THR
        |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[15:0] == high_thr_q;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("threshold readback wrong");

    // one code above unity adds one part in 16384
    property p_gain_step;
        @(posedge sys_clk) disable iff (rst)
        conv_take && conv_in.temp_chan && gain_q == 15'h4001
            && conv_in.data <= 16'hfff0
        |=> res_q.data == $past(conv_in.data) + ($past(conv_in.data) >> 14);
    endproperty
    a_gain_step: assert property (p_gain_step)
        else $error("unit gain step wrong");

    // a result above the low release point ends the low state
    property p_low_release;
        @(posedge sys_clk) disable iff (rst)
        conv_take && !below_low && {1'b0, corr} > low_release
        |=> !low_state_q;
    endproperty
    a_low_release: assert property (p_low_release)
        else $error("low state not released");

    // written ones clear flags when no conversion lands
    property p_flag_clear;
        @(posedge sys_clk) disable iff (rst)
        wr_en && reg_addr == alc_pkg::OFS_FLAGS_1 && !conv_take
        |=> (flags1_q & $past(reg_wdata[alc_pkg::EV_W-1:0]))
            == alc_pkg::EV_RST;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared by a written one");

    // a low enable freezes registers, flags and states alike
    property p_freeze;
        @(posedge sys_clk) disable iff (rst)
        !clk_en |=> $stable(gain_q) && $stable(low_hys_q)
            && $stable(flags1_q) && $stable(low_state_q);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with the enable low");

endmodule : alc_limit_check

//--- src/alc_pkg.sv
// Operation
// - temperature gain field is 15 bits, unsigned, bit 14 integer, bits 13:0 fraction
// - gain field resets to the unity code, leaving results unchanged
// - an all-zero gain code forces the corrected result to zero
// - corrected result equals raw times gain code divided by 16384; the code saturates results above 0xffff to 0xffff
// - each code step changes the gain factor by about 0.000061
// - gain correction applies only to temperature sensor conversions
// - a result below the low threshold sets the low-limit event
// - low event holds until a result exceeds threshold plus hysteresis
// - a result above the high threshold sets the high-limit event
// - high event holds until a result is below threshold minus hysteresis
// - consecutive results differing more than the limit set the step event
// - every event is reported in both interrupt flag registers
package alc_pkg;

    // byte addresses of the register map
    localparam logic [15:0] OFS_LOW_THR   = 16'h20a8;
    localparam logic [15:0] OFS_LOW_HYS   = 16'h20ac;
    localparam logic [15:0] OFS_HIGH_THR  = 16'h20b0;
    localparam logic [15:0] OFS_HIGH_HYS  = 16'h20b4;
    localparam logic [15:0] OFS_STEP_LIM  = 16'h20b8;
    localparam logic [15:0] OFS_GAIN_TRIM = 16'h2238;
    localparam logic [15:0] OFS_FLAGS_1   = 16'h20c0;
    localparam logic [15:0] OFS_MASK_1    = 16'h20c4;
    localparam logic [15:0] OFS_FLAGS_2   = 16'h20c8;
    localparam logic [15:0] OFS_MASK_2    = 16'h20cc;
    localparam logic [15:0] OFS_STATUS    = 16'h20d0;

    // field layout
    localparam int GAIN_W      = 15;
    localparam int GAIN_FRAC   = 14;
    localparam int RES_W       = 16;
    localparam int EV_W        = 3;
    localparam int EV_LOW      = 0;
    localparam int EV_HIGH     = 1;
    localparam int EV_STEP     = 2;
    localparam int ST_LOW_POS  = 0;
    localparam int ST_HIGH_POS = 1;
    localparam int ST_RES_POS  = 16;

    // reset values
    localparam logic [14:0] GAIN_RST  = 15'h4000;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [2:0]  EV_RST    = 3'h0;

    // one conversion arriving from the conversion path
    typedef struct packed {
        logic        valid;
        logic        temp_chan;
        logic [15:0] data;
    } alc_conv_t;

    // corrected result handed on
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } alc_res_t;

endpackage : alc_pkg

//--- tb/alc_conv_source.sv
// conversion path model: emits one result per start, lag + 1 cycles after the start is sampled
module alc_conv_source (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic          temp,
    input  wire logic [15:0]   data,
    input  wire logic [3:0]    lag,
    output alc_pkg::alc_conv_t conv_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        busy_q;
    logic [3:0]  cnt_q;
    logic        temp_q;
    logic [15:0] data_q;

    // data lines toggle between results so stale values never look valid
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_q   <= 1'b0;
            cnt_q    <= 4'h0;
            temp_q   <= 1'b0;
            data_q   <= 16'h0000;
            conv_out <= '0;
        end else begin
            conv_out.valid     <= 1'b0;
            conv_out.temp_chan <= ~conv_out.temp_chan;
            conv_out.data      <= ~conv_out.data;
            if (start) begin
                busy_q <= 1'b1;
                cnt_q  <= lag;
                temp_q <= temp;
                data_q <= data;
            end else if (busy_q && cnt_q == 4'h0) begin
                conv_out <= {1'b1, temp_q, data_q};
                busy_q   <= 1'b0;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : alc_conv_source

//--- tb/adc_result_limit_check_tb.sv
module adc_result_limit_check_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [14:0] gain;
        logic        temp;
        logic [15:0] raw;
        logic [15:0] exp;
    } alc_row_t;

    logic               sys_clk, rst, clk_en, reg_wr, reg_rd;
    logic [15:0]        reg_addr;
    logic [31:0]        reg_wdata, reg_rdata;
    alc_pkg::alc_conv_t conv_in;
    alc_pkg::alc_res_t  res_out;
    logic               irq_first, irq_second;
    logic               src_start, src_temp;
    logic [15:0]        src_data;
    logic [3:0]         src_lag;
    logic [2:0]         m1, m2;
    int                 err_total, checked;
    // raw times code over 16384, truncated, saturated at full scale; the last, non-temperature row passes raw
    alc_row_t rows [8] = '{
        '{15'h4000, 1'b1, 16'hc003, 16'hc003}, '{15'h2000, 1'b1, 16'h1000,
        16'h0800}, '{15'h0000, 1'b1, 16'h1234, 16'h0000}, '{15'h7fff, 1'b1,
        16'h8000, 16'hfffe}, '{15'h4001, 1'b1, 16'hc000, 16'hc003},
        '{15'h3fff, 1'b1, 16'h4000, 16'h3fff}, '{15'h7fff, 1'b1, 16'hffff,
        16'hffff}, '{15'h0000, 1'b0, 16'h1234, 16'h1234}};

    alc_limit_check u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_in(conv_in),
        .res_out(res_out), .irq_first(irq_first), .irq_second(irq_second));

    alc_conv_source u_src (.sys_clk(sys_clk), .rst(rst), .start(src_start),
        .temp(src_temp), .data(src_data), .lag(src_lag), .conv_out(conv_in));

    // 25 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, "read data");
    endtask : rd

    task automatic cv(input logic t, input logic [15:0] d, exp,
                      input logic [3:0] lag);
        int n;
        @(posedge sys_clk);
        src_start <= 1'b1;
        src_temp  <= t;
        src_data  <= d;
        src_lag   <= lag;
        @(posedge sys_clk);
        src_start <= 1'b0;
        for (n = 0; n < 40 && res_out.valid !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        chk({15'h0000, res_out.valid, res_out.data}, {16'h0001, exp},
            "corrected result");
    endtask : cv

    task automatic clr;
        wr(alc_pkg::OFS_FLAGS_1, 32'h0000_0007);
        wr(alc_pkg::OFS_FLAGS_2, 32'h0000_0007);
    endtask : clr

    // same event in both flag registers, each irq gated by its own mask
    task automatic flags(input logic [2:0] e);
        rd(alc_pkg::OFS_FLAGS_1, {29'h0, e});
        rd(alc_pkg::OFS_FLAGS_2, {29'h0, e});
        chk({31'h0, irq_first}, {31'h0, |(e & m1)}, "irq first");
        chk({31'h0, irq_second}, {31'h0, |(e & m2)}, "irq second");
    endtask : flags

    task automatic masks(input logic [2:0] a, b);
        m1 = a;
        m2 = b;
        wr(alc_pkg::OFS_MASK_1, {29'h0, a});
        wr(alc_pkg::OFS_MASK_2, {29'h0, b});
    endtask : masks

    // reset values of the limit, gain and first flag registers plus an unmapped hole
    task automatic reset_values;
        rd(alc_pkg::OFS_LOW_THR, 32'h0000_0000);
        rd(alc_pkg::OFS_LOW_HYS, 32'h0000_0000);
        rd(alc_pkg::OFS_HIGH_THR, 32'h0000_0000);
        rd(alc_pkg::OFS_HIGH_HYS, 32'h0000_0000);
        rd(alc_pkg::OFS_STEP_LIM, 32'h0000_0000);
        rd(alc_pkg::OFS_GAIN_TRIM, 32'h0000_4000);
        rd(alc_pkg::OFS_FLAGS_1, 32'h0000_0000);
        rd(16'h2100, 32'h0000_0000);
        $display("test reset values done at %0t", $time);
    endtask : reset_values

    // hang guard, well above the expected run length
    initial begin
        #(40 * 20000);
        err_total++;
        complete_run();
    end

    initial begin
        rst = 1'b1; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 16'h0000; reg_wdata = 32'h0000_0000; src_start = 1'b0;
        src_temp = 1'b0; src_data = 16'h0000; src_lag = 4'h0;
        m1 = 3'h0; m2 = 3'h0; err_total = 0; checked = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        reset_values();
        cv(1'b1, 16'h1234, 16'h1234, 4'h2);
        foreach (rows[i]) begin
            wr(alc_pkg::OFS_GAIN_TRIM, {17'h0, rows[i].gain});
            cv(rows[i].temp, rows[i].raw, rows[i].exp, 4'(i % 3));
        end
        $display("test gain rows done at %0t", $time);
        wr(alc_pkg::OFS_LOW_THR, 32'hffff_ffff);
        rd(alc_pkg::OFS_LOW_THR, 32'h0000_ffff);
        wr(alc_pkg::OFS_GAIN_TRIM, 32'hffff_ffff);
        rd(alc_pkg::OFS_GAIN_TRIM, 32'h0000_7fff);
        wr(16'h2100, 32'h1234_5678);
        rd(16'h2100, 32'h0000_0000);
        wr(alc_pkg::OFS_LOW_THR, 32'h0000_1000);
        wr(alc_pkg::OFS_LOW_HYS, 32'h0000_0100);
        wr(alc_pkg::OFS_HIGH_THR, 32'h0000_f000);
        wr(alc_pkg::OFS_HIGH_HYS, 32'h0000_0100);
        wr(alc_pkg::OFS_STEP_LIM, 32'h0000_ffff);
        masks(3'h7, 3'h2);
        cv(1'b0, 16'h1000, 16'h1000, 4'h0);
        clr();
        flags(3'h0);
        cv(1'b0, 16'h0fff, 16'h0fff, 4'h1);
        flags(3'h1);
        rd(alc_pkg::OFS_STATUS, 32'h0fff_0001);
        clr();
        cv(1'b0, 16'h1100, 16'h1100, 4'h0);
        flags(3'h1);
        cv(1'b0, 16'h1101, 16'h1101, 4'h0);
        clr();
        flags(3'h0);
        $display("test low limit done at %0t", $time);
        cv(1'b0, 16'hf000, 16'hf000, 4'h0);
        flags(3'h0);
        cv(1'b0, 16'hf001, 16'hf001, 4'h3);
        flags(3'h2);
        clr();
        cv(1'b0, 16'hef00, 16'hef00, 4'h0);
        flags(3'h2);
        cv(1'b0, 16'heeff, 16'heeff, 4'h0);
        clr();
        flags(3'h0);
        $display("test high limit done at %0t", $time);
        wr(alc_pkg::OFS_STEP_LIM, 32'h0000_0100);
        cv(1'b0, 16'h8000, 16'h8000, 4'h0);
        flags(3'h4);
        clr();
        cv(1'b0, 16'h8100, 16'h8100, 4'h0);
        flags(3'h0);
        cv(1'b0, 16'h7fff, 16'h7fff, 4'h0);
        flags(3'h4);
        $display("test step limit done at %0t", $time);
        // a write with the enable low must not land
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(alc_pkg::OFS_LOW_HYS, 32'h0000_0055);
        clk_en <= 1'b1;
        rd(alc_pkg::OFS_LOW_HYS, 32'h0000_0100);
        $display("test clock enable done at %0t", $time);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        m1 = 3'h0;
        m2 = 3'h0;
        flags(3'h0);
        reset_values();
        masks(3'h7, 3'h2);
        // first result after reset has no predecessor for the step check
        cv(1'b1, 16'h1234, 16'h1234, 4'h0);
        flags(3'h2);
        $display("test mid-run reset done at %0t", $time);
        complete_run();
    end
endmodule : adc_result_limit_check_tb
